/* core/timer_mode_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer_mode_defs.svh"

module timer_mode_core
   import timer_mode_pkg::*;
#(
   parameter int CLK_DIV = `TMR_CLK_DIV
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register bus
   input wire sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata_q,
   // interrupt controller
   input wire logic vector_zero,
   input wire logic vector_one,
   output tmr_irq_t irq_q,
   // external pins
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic timer_zero_count_pin,
   input wire logic timer_one_count_pin,
   input wire logic timer_three_count_pin,
   input wire logic count_direction_pin
);

   localparam int DIV_W = $clog2(CLK_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);

   logic [DIV_W-1:0] div_q;
   logic tick, wr_any, ovf0_ev, ovf1_ev, ev2, down2;
   logic [2:0] pin_q;
   logic fall_zero, fall_one, fall_three, cnt0_en, cnt1_en, cnt0h_en, cnt2_en;
   tmr_cfg_t cfg_zero_q, cfg_one_q;
   logic [7:0] tl0_q, th0_q, tl1_q, th1_q, tl2_q, th2_q, rcap_l_q, rcap_h_q;
   logic run_zero_q, run_one_q, ovf_zero_q, ovf_one_q;
   logic [7:0] t3_ctrl_q;
   logic [1:0] t3_mode_q;
   logic [16:0] step0, step1;
   logic [8:0] lo0_inc, hi0_inc;
   logic [7:0] tl0_d, th0_d, tl1_d, th1_d;
   logic [15:0] cnt2, rel2, cnt2_d;

   // one basic timer step for modes 0 to 2
   function automatic logic [16:0] basic_step(input tmr_mode_t m,
      input logic [7:0] th, input logic [7:0] tl);
      logic [13:0] c13;
      logic [16:0] c16, r;
      logic [8:0] c8;
      c13 = {1'b0, th, tl[4:0]} + 14'h1;
      c16 = {1'b0, th, tl} + 17'h1;
      c8 = {1'b0, tl} + 9'h1;
      case (m)
         MODE_13BIT: r = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
         MODE_16BIT: r = c16;
         MODE_RELOAD: r = {c8[8], th, c8[8] ? th : c8[7:0]};
         default: r = {1'b0, th, tl};
      endcase
      return r;
   endfunction

   assign wr_any = sfr_req.wr;

   // system clock prescaler for timer operation
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         div_q <= '0;
      else
         div_q <= tick ? '0 : div_q + DIV_W'(1);
   end

   assign tick = (div_q == DIV_LAST);

   // previous levels of the count pins
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         pin_q <= 3'h0;
      else
         pin_q <= {timer_three_count_pin, timer_one_count_pin,
                   timer_zero_count_pin};
   end

   // negative transitions on the count pins
   assign fall_zero = pin_q[0] & ~timer_zero_count_pin;
   assign fall_one = pin_q[1] & ~timer_one_count_pin;
   assign fall_three = pin_q[2] & ~timer_three_count_pin;

   // count enables of the basic timers
   always_comb
   begin
      cnt0_en = run_zero_q & (~cfg_zero_q.gate_sel | ext_irq_zero_pin)
                & (cfg_zero_q.source_sel ? fall_zero : tick);
      cnt1_en = run_one_q & (~cfg_one_q.gate_sel | ext_irq_one_pin)
                & (cfg_one_q.source_sel ? fall_one : tick);
      cnt0h_en = run_one_q & tick;
   end

   // next count values of the basic timers
   always_comb
   begin
      step0 = basic_step(cfg_zero_q.mode, th0_q, tl0_q);
      step1 = basic_step(cfg_one_q.mode, th1_q, tl1_q);
      lo0_inc = {1'b0, tl0_q} + 9'h1;
      hi0_inc = {1'b0, th0_q} + 9'h1;
      tl0_d = tl0_q;
      th0_d = th0_q;
      tl1_d = tl1_q;
      th1_d = th1_q;
      ovf0_ev = 1'b0;
      ovf1_ev = 1'b0;
      if (cfg_zero_q.mode == MODE_SPLIT)
      begin
         // split mode: low byte own timer, high byte on the other run bit
         if (cnt0_en)
         begin
            tl0_d = lo0_inc[7:0];
            ovf0_ev = lo0_inc[8];
         end
         if (cnt0h_en)
         begin
            th0_d = hi0_inc[7:0];
            ovf1_ev = hi0_inc[8];
         end
      end
      else if (cnt0_en)
         {ovf0_ev, th0_d, tl0_d} = step0;
      if (cnt1_en && cfg_one_q.mode != MODE_SPLIT)
      begin
         th1_d = step1[15:8];
         tl1_d = step1[7:0];
         if (cfg_zero_q.mode != MODE_SPLIT)
            ovf1_ev = step1[16];
      end
   end

   // timer mode control register
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_one_q <= tmr_cfg_t'(`RST_BYTE >> 4);
         cfg_zero_q <= tmr_cfg_t'(`RST_BYTE & 8'h0f);
      end
      else if (wr_any && sfr_req.addr == `OFS_TIMER_MODE_CTRL)
      begin
         cfg_one_q <= tmr_cfg_t'(sfr_req.wdata[7:4]);
         cfg_zero_q <= tmr_cfg_t'(sfr_req.wdata[3:0]);
      end
   end

   // basic timer count bytes; a software write wins over counting
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tl0_q <= `RST_BYTE;
         th0_q <= `RST_BYTE;
         tl1_q <= `RST_BYTE;
         th1_q <= `RST_BYTE;
      end
      else
      begin
         if (wr_any && sfr_req.addr == `OFS_TIMER_ZERO_LOW)
            tl0_q <= sfr_req.wdata;
         else
            tl0_q <= tl0_d;
         if (wr_any && sfr_req.addr == `OFS_TIMER_ZERO_HIGH)
            th0_q <= sfr_req.wdata;
         else
            th0_q <= th0_d;
         if (wr_any && sfr_req.addr == `OFS_TIMER_ONE_LOW)
            tl1_q <= sfr_req.wdata;
         else
            tl1_q <= tl1_d;
         if (wr_any && sfr_req.addr == `OFS_TIMER_ONE_HIGH)
            th1_q <= sfr_req.wdata;
         else
            th1_q <= th1_d;
      end
   end

   // run bits and overflow flags; an overflow wins over any clear
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         run_zero_q <= 1'b0;
         run_one_q <= 1'b0;
         ovf_zero_q <= 1'b0;
         ovf_one_q <= 1'b0;
      end
      else
      begin
         if (wr_any && sfr_req.addr == `OFS_TIMER_CTRL)
         begin
            run_zero_q <= sfr_req.wdata[`POS_ZERO_RUN];
            run_one_q <= sfr_req.wdata[`POS_ONE_RUN];
         end
         if (ovf0_ev)
            ovf_zero_q <= 1'b1;
         else if (vector_zero)
            ovf_zero_q <= 1'b0;
         else if (wr_any && sfr_req.addr == `OFS_TIMER_CTRL)
            ovf_zero_q <= sfr_req.wdata[`POS_ZERO_OVF];
         if (ovf1_ev)
            ovf_one_q <= 1'b1;
         else if (vector_one)
            ovf_one_q <= 1'b0;
         else if (wr_any && sfr_req.addr == `OFS_TIMER_CTRL)
            ovf_one_q <= sfr_req.wdata[`POS_ONE_OVF];
      end
   end

   // third timer: count, compare and reload
   always_comb
   begin
      cnt2 = {th2_q, tl2_q};
      rel2 = {rcap_h_q, rcap_l_q};
      cnt2_en = t3_ctrl_q[`POS_THREE_RUN]
                & (t3_ctrl_q[`POS_THREE_SRC] ? fall_three : tick);
      down2 = t3_mode_q[`POS_UP_DOWN_EN] & ~count_direction_pin;
      cnt2_d = cnt2;
      ev2 = 1'b0;
      if (cnt2_en)
      begin
         if (down2)
         begin
            if (cnt2 == rel2)
            begin
               cnt2_d = 16'hffff;
               ev2 = 1'b1;
            end
            else
               cnt2_d = cnt2 - 16'h1;
         end
         else if (cnt2 == 16'hffff)
         begin
            cnt2_d = rel2;
            ev2 = 1'b1;
         end
         else
            cnt2_d = cnt2 + 16'h1;
      end
   end

   // third timer count bytes and reload register pair
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tl2_q <= `RST_BYTE;
         th2_q <= `RST_BYTE;
         rcap_l_q <= `RST_BYTE;
         rcap_h_q <= `RST_BYTE;
      end
      else
      begin
         if (wr_any && sfr_req.addr == `OFS_TIMER_THREE_LOW)
            tl2_q <= sfr_req.wdata;
         else
            tl2_q <= cnt2_d[7:0];
         if (wr_any && sfr_req.addr == `OFS_TIMER_THREE_HIGH)
            th2_q <= sfr_req.wdata;
         else
            th2_q <= cnt2_d[15:8];
         if (wr_any && sfr_req.addr == `OFS_RELOAD_LOW)
            rcap_l_q <= sfr_req.wdata;
         if (wr_any && sfr_req.addr == `OFS_RELOAD_HIGH)
            rcap_h_q <= sfr_req.wdata;
      end
   end

   // third timer control and mode; flag set and toggle win over writes
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         t3_ctrl_q <= `RST_BYTE;
         t3_mode_q <= 2'h0;
      end
      else
      begin
         if (wr_any && sfr_req.addr == `OFS_TIMER_THREE_MODE)
            t3_mode_q <= sfr_req.wdata[1:0];
         if (wr_any && sfr_req.addr == `OFS_TIMER_THREE_CTRL)
            t3_ctrl_q <= sfr_req.wdata;
         if (ev2)
         begin
            t3_ctrl_q[`POS_THREE_OVF] <= 1'b1;
            if (t3_mode_q[`POS_UP_DOWN_EN])
               t3_ctrl_q[`POS_THREE_EXT] <= ~t3_ctrl_q[`POS_THREE_EXT];
         end
      end
   end

   // interrupt requests; the toggling flag requests nothing in up/down
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         irq_q <= '0;
      else
      begin
         irq_q.timer_zero <= ovf0_ev | (ovf_zero_q & ~vector_zero);
         irq_q.timer_one <= ovf1_ev | (ovf_one_q & ~vector_one);
         irq_q.timer_three <= ev2 | t3_ctrl_q[`POS_THREE_OVF]
            | (t3_ctrl_q[`POS_THREE_EXT] & ~t3_mode_q[`POS_UP_DOWN_EN]);
      end
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         sfr_rdata_q <= 8'h00;
      else if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            `OFS_TIMER_CTRL: sfr_rdata_q <= {ovf_one_q, run_one_q,
                                             ovf_zero_q, run_zero_q, 4'h0};
            `OFS_TIMER_MODE_CTRL: sfr_rdata_q <= {cfg_one_q, cfg_zero_q};
            `OFS_TIMER_ZERO_LOW: sfr_rdata_q <= tl0_q;
            `OFS_TIMER_ONE_LOW: sfr_rdata_q <= tl1_q;
            `OFS_TIMER_ZERO_HIGH: sfr_rdata_q <= th0_q;
            `OFS_TIMER_ONE_HIGH: sfr_rdata_q <= th1_q;
            `OFS_TIMER_THREE_CTRL: sfr_rdata_q <= t3_ctrl_q;
            `OFS_TIMER_THREE_MODE: sfr_rdata_q <= {6'h0, t3_mode_q};
            `OFS_RELOAD_LOW: sfr_rdata_q <= rcap_l_q;
            `OFS_RELOAD_HIGH: sfr_rdata_q <= rcap_h_q;
            `OFS_TIMER_THREE_LOW: sfr_rdata_q <= tl2_q;
            `OFS_TIMER_THREE_HIGH: sfr_rdata_q <= th2_q;
            default: sfr_rdata_q <= 8'h00;
         endcase
      end
   end

endmodule

`default_nettype wire

/* inc/timer_mode_defs.svh */
`ifndef TIMER_MODE_DEFS_SVH
`define TIMER_MODE_DEFS_SVH

// register offsets on the special function register bus
`define OFS_TIMER_CTRL        8'h88
`define OFS_TIMER_MODE_CTRL   8'h89
`define OFS_TIMER_ZERO_LOW    8'h8a
`define OFS_TIMER_ONE_LOW     8'h8b
`define OFS_TIMER_ZERO_HIGH   8'h8c
`define OFS_TIMER_ONE_HIGH    8'h8d
`define OFS_TIMER_THREE_CTRL  8'hc8
`define OFS_TIMER_THREE_MODE  8'hc9
`define OFS_RELOAD_LOW        8'hca
`define OFS_RELOAD_HIGH       8'hcb
`define OFS_TIMER_THREE_LOW   8'hcc
`define OFS_TIMER_THREE_HIGH  8'hcd

// reset value shared by the count, reload, mode control and third timer control registers
`define RST_BYTE              8'h00

// field positions in the timer control register
`define POS_ONE_OVF           7
`define POS_ONE_RUN           6
`define POS_ZERO_OVF          5
`define POS_ZERO_RUN          4

// field positions in the third timer control and mode registers
`define POS_THREE_OVF         7
`define POS_THREE_EXT         6
`define POS_THREE_RUN         2
`define POS_THREE_SRC         1
`define POS_UP_DOWN_EN        0

// system clock division for timer operation
`define TMR_CLK_DIV           6

`endif

/* inc/timer_mode_pkg.sv */
`default_nettype none
package timer_mode_pkg;

   // two-bit mode field of a basic timer
   typedef enum logic [1:0]
   {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } tmr_mode_t;

   // one half of the timer mode control register
   typedef struct packed
   {
      logic gate_sel;
      logic source_sel;
      tmr_mode_t mode;
   } tmr_cfg_t;

   // special function register bus request
   typedef struct packed
   {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_t;

   // interrupt requests towards the interrupt controller
   typedef struct packed
   {
      logic timer_zero;
      logic timer_one;
      logic timer_three;
   } tmr_irq_t;

endpackage

`default_nettype wire

/* verification/sfr_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sfr_cpu_model
   import timer_mode_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // register bus
   output var sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata_q,
   // vectoring
   output var logic vector_zero,
   output var logic vector_one
);
   // idle bus from time zero
   initial
   begin
      sfr_req = '0;
      vector_zero = 1'b0;
      vector_one = 1'b0;
   end
   // one write, held up to its taking edge
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge ref_clk);
      #1 sfr_req.wr = 1'b0;
   endtask
   // one read, data taken after its edge
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] q);
      @(posedge ref_clk);
      #1 sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge ref_clk);
      #1 sfr_req.rd = 1'b0;
      q = sfr_rdata_q;
   endtask
   // write then read back to back
   task automatic sfr_wr_rd(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge ref_clk);
      #1 sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge ref_clk);
      #1 sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: d};
      @(posedge ref_clk);
      #1 sfr_req.rd = 1'b0;
      q = sfr_rdata_q;
   endtask
   // vector pulse, clears a basic flag
   task automatic vec(input logic one);
      @(posedge ref_clk);
      #1 vector_zero = !one;
      vector_one = one;
      @(posedge ref_clk);
      #1 vector_zero = 1'b0;
      vector_one = 1'b0;
   endtask
endmodule
`default_nettype wire

/* verification/timer_mode_and_updown_reload_test.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_mode_and_updown_reload_test
   import timer_mode_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic ext0 = 1'b0, ext1 = 1'b0, dir = 1'b0;
   logic [2:0] pins = 3'h0;
   sfr_req_t sfr_req;
   logic [7:0] sfr_rdata_q;
   logic vector_zero, vector_one;
   tmr_irq_t irq_q;
   int n_mismatch = 0, n_checks = 0;
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;
   timer_mode_core #(.CLK_DIV(2)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .sfr_req(sfr_req),
      .sfr_rdata_q(sfr_rdata_q), .vector_zero(vector_zero),
      .vector_one(vector_one), .irq_q(irq_q), .ext_irq_zero_pin(ext0),
      .ext_irq_one_pin(ext1), .timer_zero_count_pin(pins[0]),
      .timer_one_count_pin(pins[1]), .timer_three_count_pin(pins[2]),
      .count_direction_pin(dir));
   sfr_cpu_model cpu (
      .ref_clk(ref_clk), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
      .vector_zero(vector_zero), .vector_one(vector_one));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu.sfr_write(a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      cpu.sfr_read(a, q);
      chk(q, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // falling edges on one count pin
   task automatic pulse(input int idx, input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         #1 pins[idx] = 1'b1;
         @(posedge ref_clk);
         #1 pins[idx] = 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task automatic t_regs;
      logic [7:0] q;
      int i;
      for (i = 0; i < 5; i++)
         rc(8'h89 + 8'(i), 8'h00);
      rc(8'h00, 8'h00);
      chk({5'h00, irq_q}, 8'h00);
      for (i = 0; i < 5; i++)
      begin
         cpu.sfr_wr_rd(8'h89 + 8'(i), 8'h5a + 8'(i), q);
         chk(q, 8'h5a + 8'(i));
      end
      cpu.sfr_wr_rd(8'hcb, 8'hc3, q);
      chk(q, 8'hc3);
      $display("test regs done");
   endtask
   task automatic t_zero;
      wr(8'h89, 8'h05);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'h12);
      wr(8'h88, 8'h10);
      pulse(0, 3);
      rc(8'h8a, 8'h01);
      rc(8'h8c, 8'h13);
      wr(8'h89, 8'h04);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'h00);
      pulse(0, 3);
      rc(8'h8a, 8'he1);
      rc(8'h8c, 8'h01);
      wr(8'h89, 8'h06);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'h40);
      pulse(0, 3);
      rc(8'h8a, 8'h41);
      rc(8'h8c, 8'h40);
      rc(8'h88, 8'h30);
      chk({7'h00, irq_q.timer_zero}, 8'h01);
      cpu.vec(1'b0);
      idle(2);
      chk({7'h00, irq_q.timer_zero}, 8'h00);
      // gated 16-bit count: pin edges pass only with gate pin high
      wr(8'h89, 8'h0d);
      pulse(0, 1);
      rc(8'h8a, 8'h41);
      ext0 = 1'b1;
      pulse(0, 1);
      rc(8'h8a, 8'h42);
      $display("test timer zero done");
   endtask
   task automatic t_one;
      logic [7:0] q;
      wr(8'h89, 8'h60);
      wr(8'h8b, 8'hff);
      wr(8'h8d, 8'h80);
      wr(8'h88, 8'h40);
      pulse(1, 2);
      rc(8'h8b, 8'h81);
      rc(8'h8d, 8'h80);
      chk({7'h00, irq_q.timer_one}, 8'h01);
      wr(8'h89, 8'h70);
      pulse(1, 2);
      rc(8'h8b, 8'h81);
      cpu.vec(1'b1);
      idle(2);
      chk({7'h00, irq_q.timer_one}, 8'h00);
      wr(8'h89, 8'h90);
      wr(8'h8b, 8'h00);
      idle(20);
      rc(8'h8b, 8'h00);
      ext1 = 1'b1;
      idle(20);
      wr(8'h88, 8'h00);
      cpu.sfr_read(8'h8b, q);
      chk({7'h00, q != 8'h00}, 8'h01);
      $display("test timer one done");
   endtask
   task automatic t_split;
      int k;
      wr(8'h89, 8'h07);
      wr(8'h8a, 8'hff);
      wr(8'h8c, 8'hfe);
      wr(8'h88, 8'h10);
      pulse(0, 1);
      rc(8'h8a, 8'h00);
      rc(8'h8c, 8'hfe);
      wr(8'h88, 8'h50);
      for (k = 0; k < 40 && irq_q.timer_one !== 1'b1; k++)
         idle(1);
      chk({7'h00, irq_q.timer_one}, 8'h01);
      wr(8'h88, 8'h00);
      $display("test split done");
   endtask
   task automatic t_three;
      logic [7:0] q;
      wr(8'hc9, 8'h01);
      wr(8'hca, 8'h34);
      wr(8'hcb, 8'h12);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      dir = 1'b1;
      wr(8'hc8, 8'h06);
      pulse(2, 2);
      rc(8'hcc, 8'h34);
      rc(8'hcd, 8'h12);
      rc(8'hc8, 8'hc6);
      chk({7'h00, irq_q.timer_three}, 8'h01);
      dir = 1'b0;
      pulse(2, 2);
      rc(8'hcc, 8'hfe);
      rc(8'hcd, 8'hff);
      rc(8'hc8, 8'h86);
      wr(8'hc8, 8'h06);
      idle(2);
      chk({7'h00, irq_q.timer_three}, 8'h00);
      wr(8'hc9, 8'h00);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      pulse(2, 2);
      rc(8'hcc, 8'h34);
      rc(8'hc8, 8'h86);
      wr(8'hc8, 8'h02);
      pulse(2, 2);
      rc(8'hcc, 8'h34);
      wr(8'hc8, 8'h04);
      idle(12);
      wr(8'hc8, 8'h00);
      cpu.sfr_read(8'hcc, q);
      chk({7'h00, q != 8'h34}, 8'h01);
      $display("test third timer done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence after reset
   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1 rstn = 1'b1;
      t_regs;
      t_zero;
      t_one;
      t_split;
      t_three;
      tally_and_finish;
   end
   // watchdog against a hang
   initial
   begin
      #200000;
      n_mismatch++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule
`default_nettype wire

/* verification/timer_mode_checker_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_mode_checker
   import timer_mode_pkg::*;
#(
   parameter int CLK_DIV = 6
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register bus and vectoring
   input wire sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata_q,
   input wire logic vector_zero,
   input wire logic vector_one,
   // interrupt requests
   input wire tmr_irq_t irq_q
);
   // writes that may clear flags
   logic wr_ctl, wr_three;
   assign wr_ctl = sfr_req.wr && sfr_req.addr == 8'h88;
   assign wr_three = sfr_req.wr && sfr_req.addr inside {8'hc8, 8'hc9};
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   property p_reset_idle;
      $rose(rstn) |-> irq_q == '0 && sfr_rdata_q == 8'h00;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("state not clear after reset");
   property p_rdata_hold;
      !sfr_req.rd |=> $stable(sfr_rdata_q);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   property p_unmapped;
      sfr_req.rd && sfr_req.addr == 8'h00 |=> sfr_rdata_q == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ctrl_low;
      sfr_req.rd && sfr_req.addr == 8'h88 |=> sfr_rdata_q[3:0] == 4'h0;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low)
      else $error("unused control bits not zero");
   property p_readback;
      (sfr_req.wr && sfr_req.addr inside {8'h89, 8'hca, 8'hcb}) ##1
      (sfr_req.rd && !sfr_req.wr && sfr_req.addr == $past(sfr_req.addr))
      |=> sfr_rdata_q == $past(sfr_req.wdata, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("register readback differs");
   property p_three_sticky;
      irq_q.timer_three && !wr_three && !$past(wr_three)
      |=> irq_q.timer_three;
   endproperty
   a_three_sticky: assert property (p_three_sticky)
      else $error("third timer flag dropped by itself");
   property p_zero_hold;
      irq_q.timer_zero && !vector_zero && !$past(vector_zero) && !wr_ctl
      && !$past(wr_ctl) |=> irq_q.timer_zero;
   endproperty
   a_zero_hold: assert property (p_zero_hold)
      else $error("timer zero flag dropped without vector");
   property p_one_hold;
      irq_q.timer_one && !vector_one && !$past(vector_one) && !wr_ctl
      && !$past(wr_ctl) |=> irq_q.timer_one;
   endproperty
   a_one_hold: assert property (p_one_hold)
      else $error("timer one flag dropped without vector");
endmodule
bind timer_mode_core timer_mode_checker #(.CLK_DIV(CLK_DIV)) chk (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .sfr_req(sfr_req),
   .sfr_rdata_q(sfr_rdata_q),
   .vector_zero(vector_zero),
   .vector_one(vector_one),
   .irq_q(irq_q)
);
`default_nettype wire
